// file: src/ldc_pkg.sv
// package of the display-control decoder: timing, reset values, field positions
// assumes a 100 MHz CLK that stands in for the display oscillator
package ldc_pkg;

  typedef enum logic [1:0] {LDC_ONE_LINE, LDC_TWO_LINE, LDC_FOUR_LINE} ldc_lines_t;
  typedef enum logic [1:0] {LDC_RAM_TEXT, LDC_RAM_GLYPH, LDC_RAM_ICON} ldc_ram_t;

  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BUSY_TIME_NS   = 39000;
  localparam int BUSY_CYCLES    = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_TIME_MS  = 370;
  localparam int BLINK_CYCLES   = (BLINK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int FONT6_NUM      = 6;
  localparam int FONT5_NUM      = 5;
  localparam int FONT_DEN       = 5;
  localparam logic [2:0] DIV_NONE  = 3'h1;
  localparam logic [2:0] DIV_MULTI = 3'h2;
  localparam logic [2:0] DIV_ONE   = 3'h4;

  // instruction bit positions
  localparam int BIT_ADDR_TEXT  = 7;
  localparam int BIT_ADDR_GLYPH = 6;
  localparam int BIT_FUNC_SET   = 5;
  localparam int BIT_SHIFT      = 4;
  localparam int BIT_DISP_CTRL  = 3;

  // reset values
  localparam logic RST_DISPLAY   = 1'b0;
  localparam logic RST_CURSOR    = 1'b0;
  localparam logic RST_BLINK     = 1'b0;
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic RST_LINE_CNT  = 1'b0;
  localparam logic RST_PAGE      = 1'b0;
  localparam logic [6:0] RST_ADDR = 7'h00;

  // text address map
  localparam logic [6:0] ONE_LAST    = 7'h4F;
  localparam logic [6:0] TWO_L1_LAST = 7'h27;
  localparam logic [6:0] TWO_L2_BASE = 7'h40;
  localparam logic [6:0] TWO_L2_LAST = 7'h67;
  localparam logic [4:0] FOUR_LAST   = 5'h13;
  localparam logic [6:0] LEN_ONE     = 7'h50;
  localparam logic [6:0] LEN_TWO     = 7'h28;
  localparam logic [6:0] LEN_FOUR    = 7'h14;
  localparam logic [6:0] GLYPH_MASK  = 7'h3F;
  localparam logic [6:0] ICON_MASK   = 7'h0F;
  localparam logic [5:0] ROW_MASK6   = 6'h3F;
  localparam logic [5:0] ROW_MASK5   = 6'h1F;

endpackage

// file: src/ldc_busy_timer.sv
// busy timer: holds busy for a loaded number of cycles
// assumes load is at least one
`timescale 1ns/1ps
module ldc_busy_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic [31:0] load,
  output logic             busy
);
  import ldc_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        busy;
  } ldc_busy_st_t;

  ldc_busy_st_t s_q;
  ldc_busy_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.cnt  = load - 32'h1;
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      if (s_q.cnt == 32'h0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;

endmodule // ldc_busy_timer

// file: src/ldc_blink_timer.sv
// blink timer: phase toggles every limit cycles while enabled
// assumes limit is at least one
`timescale 1ns/1ps
module ldc_blink_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        enable,
  input  wire logic [31:0] limit,
  output logic             phase
);
  import ldc_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
  } ldc_blink_st_t;

  ldc_blink_st_t s_q;
  ldc_blink_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d = '0;
    end else if (s_q.cnt >= limit - 32'h1) begin
      s_d.cnt   = 32'h0;
      s_d.phase = ~s_q.phase;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.phase;

endmodule // ldc_blink_timer

// file: src/ldc_decoder.sv
// display-control instruction decoder and its control state
// assumes instruction bytes arrive synchronous to CLK, one per INSTR_VALID cycle on the 8-bit bus, one nibble per cycle on the 4-bit bus
//
// Overview of operation
// - page 0, 00001DCB sets display, cursor, blink
// - display off blanks panel, text RAM kept
// - cursor off hides cursor, direction kept
// - blink alternates all-on and character, 370 ms with undivided clock
// - page 1, 00001xxx loads width, inversion, four-line
// - six-dot font lengthens execution by 6/5
// - six-dot glyphs use row bits 5..0
// - inversion toggles cursor cell, overrides cursor/blink
// - four-line overrides line count; else one/two
// - page 0 cursor shift moves address pointer
// - display shift moves all lines, pointer kept
// - two-line cursor wraps after 40th digit
// - four-line cursor wraps after 20th digit
// - page 1, 0001xxxx stores per-line scroll enables
// - function set selects 8-bit or 4-bit bus
// - line count ignored while four-line set
// - page bit selects page-1 instruction set
// - glyph blink enable, top two stored bits
// - low power divides clock by 4 or 2 while EXTENSION_DRIVER_SELECT is low
// - low power reduces frame rate to 5/6 while EXTENSION_DRIVER_SELECT is low
// - address set targets glyph or icon RAM
// - every instruction busy 39 us with five-dot font and undivided clock
`timescale 1ns/1ps
module ldc_decoder #(
  parameter int BUSY_CYCLES_P  = ldc_pkg::BUSY_CYCLES,
  parameter int BLINK_CYCLES_P = ldc_pkg::BLINK_CYCLES
) (
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire logic              INSTR_VALID,
  input  wire logic [7:0]        INSTR_DATA,
  input  wire logic              EXTENSION_DRIVER_SELECT,
  output logic                   BUSY,
  output logic                   PANEL_DRIVE,
  output logic                   CURSOR_ENABLE,
  output logic                   BLINK_ENABLE,
  output logic                   CURSOR_SHOWN,
  output logic                   CURSOR_ALL_ON,
  output logic                   CURSOR_INVERT,
  output logic                   FONT_WIDTH_SELECT,
  output logic [5:0]             GLYPH_ROW_MASK,
  output logic                   FOUR_LINE_ENABLE,
  output ldc_pkg::ldc_lines_t    LINE_MODE,
  output logic [3:0]             LINE_SCROLL_ENABLE,
  output logic                   BUS_WIDTH_SELECT,
  output logic                   PAGE_BIT,
  output logic                   GLYPH_BLINK_ENABLE,
  output logic                   LOW_POWER_ENABLE,
  output logic [2:0]             CLOCK_DIVIDE,
  output logic                   FRAME_RATE_REDUCED,
  output logic [6:0]             ADDRESS_POINTER,
  output ldc_pkg::ldc_ram_t      RAM_TARGET,
  output logic [6:0]             DISPLAY_SHIFT_OFFSET,
  output logic                   DISPLAY_SHIFT_PULSE
);
  import ldc_pkg::*;

  typedef struct packed {
    logic       de;
    logic       ce;
    logic       be;
    logic       font6;
    logic       inv;
    logic       four;
    logic       n;
    logic       bus8;
    logic       page;
    logic       gbe;
    logic       lowpow;
    logic [3:0] hs;
    logic [6:0] ap;
    ldc_ram_t   tgt;
    logic [6:0] soff;
    logic       spulse;
    logic       nib_ph;
    logic [3:0] nib_hi;
    logic       cur_show;
    logic       cur_all;
    logic       cur_inv;
    logic [5:0] row_mask;
    ldc_lines_t lines;
    logic [2:0] div;
    logic       frame_red;
  } ldc_dec_st_t;

  ldc_dec_st_t s_q;
  ldc_dec_st_t s_d;
  logic        busy;
  logic        phase;
  logic        exec;
  logic [7:0]  byte_w;
  logic [31:0] busy_load;
  logic [31:0] blink_limit;

  //////////////////////////////////////////////////////////////////////////////
  // address stepping

  function automatic logic [6:0] text_step(input logic [6:0] a, input logic right,
                                           input ldc_lines_t lines);
    logic [6:0] r;
    r = right ? a + 7'h1 : a - 7'h1;
    case (lines)
      LDC_ONE_LINE: begin
        if (right && a == ONE_LAST) r = 7'h00;
        else if (!right && a == 7'h00) r = ONE_LAST;
      end
      LDC_TWO_LINE: begin
        if (right && a == TWO_L1_LAST) r = TWO_L2_BASE;
        else if (right && a == TWO_L2_LAST) r = 7'h00;
        else if (!right && a == TWO_L2_BASE) r = TWO_L1_LAST;
        else if (!right && a == 7'h00) r = TWO_L2_LAST;
      end
      LDC_FOUR_LINE: begin
        if (right && a[4:0] == FOUR_LAST) r = {a[6:5] + 2'h1, 5'h00};
        else if (!right && a[4:0] == 5'h00) r = {a[6:5] - 2'h1, FOUR_LAST};
      end
      default: r = a;
    endcase
    return r;
  endfunction

  function automatic logic [6:0] line_len(input ldc_lines_t lines);
    case (lines)
      LDC_TWO_LINE:  return LEN_TWO;
      LDC_FOUR_LINE: return LEN_FOUR;
      default:       return LEN_ONE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decode and execute

  always_comb begin
    int fmul;
    fmul = FONT5_NUM;
    s_d = s_q;
    s_d.spulse = 1'b0;
    exec = 1'b0;
    byte_w = INSTR_DATA;
    // instructions are refused while busy
    if (INSTR_VALID && !busy) begin
      if (s_q.bus8) begin
        exec = 1'b1;
      end else if (!s_q.nib_ph) begin
        s_d.nib_hi = INSTR_DATA[7:4];
        s_d.nib_ph = 1'b1;
      end else begin
        byte_w = {s_q.nib_hi, INSTR_DATA[7:4]};
        s_d.nib_ph = 1'b0;
        exec = 1'b1;
      end
    end
    if (exec) begin
      if (byte_w[BIT_ADDR_TEXT]) begin
        if (!s_q.page) begin
          s_d.ap  = byte_w[6:0];
          s_d.tgt = LDC_RAM_TEXT;
        end
      end else if (byte_w[BIT_ADDR_GLYPH]) begin
        if (!s_q.page) begin
          s_d.ap  = {1'b0, byte_w[5:0]};
          s_d.tgt = LDC_RAM_GLYPH;
        end else begin
          s_d.ap  = {3'h0, byte_w[3:0]};
          s_d.tgt = LDC_RAM_ICON;
        end
      end else if (byte_w[BIT_FUNC_SET]) begin
        s_d.bus8 = byte_w[4];
        s_d.n    = byte_w[3];
        s_d.page = byte_w[2];
        if (s_q.page) begin
          s_d.gbe = byte_w[1];
          s_d.lowpow = byte_w[0];
        end
      end else if (byte_w[BIT_SHIFT]) begin
        if (s_q.page) begin
          s_d.hs = byte_w[3:0];
        end else if (byte_w[3]) begin
          s_d.spulse = 1'b1;
          if (byte_w[2]) begin
            s_d.soff = (s_q.soff + 7'h1 >= line_len(s_q.lines)) ? 7'h00 : s_q.soff + 7'h1;
          end else begin
            s_d.soff = (s_q.soff == 7'h00) ? line_len(s_q.lines) - 7'h1 : s_q.soff - 7'h1;
          end
        end else begin
          case (s_q.tgt)
            LDC_RAM_TEXT:  s_d.ap = text_step(s_q.ap, byte_w[2], s_q.lines);
            LDC_RAM_GLYPH: s_d.ap = (byte_w[2] ? s_q.ap + 7'h1 : s_q.ap - 7'h1) & GLYPH_MASK;
            default:       s_d.ap = (byte_w[2] ? s_q.ap + 7'h1 : s_q.ap - 7'h1) & ICON_MASK;
          endcase
        end
      end else if (byte_w[BIT_DISP_CTRL]) begin
        if (s_q.page) begin
          s_d.font6 = byte_w[2];
          s_d.inv   = byte_w[1];
          s_d.four  = byte_w[0];
        end else begin
          s_d.de = byte_w[2];
          s_d.ce = byte_w[1];
          s_d.be = byte_w[0];
        end
      end
    end
    // derived, registered outputs
    s_d.lines = s_d.four ? LDC_FOUR_LINE : (s_d.n ? LDC_TWO_LINE : LDC_ONE_LINE);
    s_d.row_mask = s_d.font6 ? ROW_MASK6 : ROW_MASK5;
    s_d.frame_red = s_d.lowpow && !EXTENSION_DRIVER_SELECT;
    if (s_d.frame_red) begin
      s_d.div = (s_d.lines == LDC_ONE_LINE) ? DIV_ONE : DIV_MULTI;
    end else begin
      s_d.div = DIV_NONE;
    end
    s_d.cur_show = s_d.de && !s_d.inv && s_d.ce;
    s_d.cur_all  = s_d.de && !s_d.inv && s_d.be && phase;
    s_d.cur_inv  = s_d.de && s_d.inv && phase;
    if (s_d.font6) begin
      fmul = FONT6_NUM;
    end
    busy_load   = 32'(BUSY_CYCLES_P * fmul / FONT_DEN * int'(s_d.div));
    blink_limit = 32'(BLINK_CYCLES_P * int'(s_q.div));
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q       <= '0;
      s_q.de    <= RST_DISPLAY;
      s_q.ce    <= RST_CURSOR;
      s_q.be    <= RST_BLINK;
      s_q.bus8  <= RST_BUS_WIDTH;
      s_q.n     <= RST_LINE_CNT;
      s_q.page  <= RST_PAGE;
      s_q.ap    <= RST_ADDR;
      s_q.tgt   <= LDC_RAM_TEXT;
      s_q.lines <= LDC_ONE_LINE;
      s_q.row_mask <= ROW_MASK5;
      s_q.div   <= DIV_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timers

  ldc_busy_timer u_busy (
    .clk     (CLK),
    .reset_n (RESET_N),
    .start   (exec),
    .load    (busy_load),
    .busy    (busy)
  );

  ldc_blink_timer u_blink (
    .clk     (CLK),
    .reset_n (RESET_N),
    .enable  (s_q.be || s_q.inv),
    .limit   (blink_limit),
    .phase   (phase)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign BUSY                 = busy;
  assign PANEL_DRIVE          = s_q.de;
  assign CURSOR_ENABLE        = s_q.ce;
  assign BLINK_ENABLE         = s_q.be;
  assign CURSOR_SHOWN         = s_q.cur_show;
  assign CURSOR_ALL_ON        = s_q.cur_all;
  assign CURSOR_INVERT        = s_q.cur_inv;
  assign FONT_WIDTH_SELECT    = s_q.font6;
  assign GLYPH_ROW_MASK       = s_q.row_mask;
  assign FOUR_LINE_ENABLE     = s_q.four;
  assign LINE_MODE            = s_q.lines;
  assign LINE_SCROLL_ENABLE   = s_q.hs;
  assign BUS_WIDTH_SELECT     = s_q.bus8;
  assign PAGE_BIT             = s_q.page;
  assign GLYPH_BLINK_ENABLE   = s_q.gbe;
  assign LOW_POWER_ENABLE     = s_q.lowpow;
  assign CLOCK_DIVIDE         = s_q.div;
  assign FRAME_RATE_REDUCED   = s_q.frame_red;
  assign ADDRESS_POINTER      = s_q.ap;
  assign RAM_TARGET           = s_q.tgt;
  assign DISPLAY_SHIFT_OFFSET = s_q.soff;
  assign DISPLAY_SHIFT_PULSE  = s_q.spulse;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  disp_ctrl_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    exec && byte_w[7:3] == 5'h01 && !s_q.page |=> PANEL_DRIVE == $past(byte_w[2])
      && CURSOR_ENABLE == $past(byte_w[1]) && BLINK_ENABLE == $past(byte_w[0]))
    else $error("display control not loaded");
  panel_blank_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    !PANEL_DRIVE |-> !CURSOR_SHOWN && !CURSOR_ALL_ON && !CURSOR_INVERT)
    else $error("cursor shown on blank panel");
  font_mode_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    exec && byte_w[7:3] == 5'h01 && s_q.page |=> FONT_WIDTH_SELECT == $past(byte_w[2])
      && FOUR_LINE_ENABLE == $past(byte_w[0]) && $stable(PANEL_DRIVE))
    else $error("extended function set not loaded");
  glyph_mask_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    GLYPH_ROW_MASK == (FONT_WIDTH_SELECT ? 6'h3F : 6'h1F))
    else $error("glyph row mask wrong");
  invert_ovr_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_q.inv |-> !CURSOR_SHOWN && !CURSOR_ALL_ON)
    else $error("cursor enables not overridden");
  four_line_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    FOUR_LINE_ENABLE |-> LINE_MODE == LDC_FOUR_LINE)
    else $error("four-line mode not taken");
  cursor_move_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    exec && byte_w[7:2] == 6'h05 && !s_q.page && s_q.tgt == LDC_RAM_GLYPH
      |=> ADDRESS_POINTER == (($past(ADDRESS_POINTER) + 7'h1) & 7'h3F))
    else $error("cursor right did not increment");
  disp_shift_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    exec && byte_w[7:3] == 5'h03 && !s_q.page |=> $stable(ADDRESS_POINTER)
      && DISPLAY_SHIFT_PULSE ##1 !DISPLAY_SHIFT_PULSE)
    else $error("display shift moved pointer");
  wrap_two_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    exec && byte_w[7:2] == 6'h05 && !s_q.page && s_q.tgt == LDC_RAM_TEXT
      && s_q.lines == LDC_TWO_LINE && s_q.ap == 7'h27 |=> ADDRESS_POINTER == 7'h40)
    else $error("two-line wrap missed");
  busy_start_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    exec |=> BUSY [*8])
    else $error("busy not held after instruction");

endmodule // ldc_decoder

// file: verification/ldc_host_model.sv
// host model: issues instruction bytes on the decoder's instruction port
// assumes calls come from the bench after reset has been released
`timescale 1ns/1ps
module ldc_host_model (
  input  wire logic       clk,
  input  wire logic       busy,
  output logic            instr_valid,
  output logic [7:0]      instr_data
);
  logic bus8 = 1'b1;

  initial begin
    instr_valid = 1'b0;
    instr_data  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // rude skips the idle wait so the byte lands while the device is busy
  task automatic send(input logic [7:0] b, input bit rude, output bit ok);
    int n;
    n = 0;
    while (!rude && busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (n < 2000);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_data  <= bus8 ? b : {b[7:4], ~b[3:0]}; // high nibble first
    if (!bus8) begin
      @(posedge clk);
      instr_data <= {b[3:0], b[7:4]};
    end
    @(posedge clk);
    instr_valid <= 1'b0;
    instr_data  <= ~instr_data;
    if (b[7:5] == 3'b001) begin
      bus8 = b[4];
    end
  endtask
endmodule // ldc_host_model

// file: verification/lcd_display_control_decoder_tb.sv
// bench for the display-control decoder: scenario tasks and verdict
// assumes short busy and blink counts handed to the decoder below
`timescale 1ns/1ps
module lcd_display_control_decoder_tb;
  import ldc_pkg::*;
  localparam int BUSY_P  = 10;
  localparam int BLINK_P = 4;
  logic       clk     = 1'b0;
  logic       reset_n = 1'b0;
  logic       xdrv_sel = 1'b0;
  logic       instr_valid;
  logic [7:0] instr_data;
  logic       busy, panel, cur_en, blink_en, cur_shown, all_on, cur_inv;
  logic       font6, four, bw, page, gblink, lowpow, slow, pulse;
  logic [5:0] row_mask;
  logic [3:0] scroll;
  logic [2:0] div;
  logic [6:0] ptr, offset;
  ldc_lines_t line_mode;
  ldc_ram_t   target;
  int         err_count = 0;
  int         checked   = 0;
  int         lat       = BUSY_P;
  int         pulses;

  always #5 clk = ~clk;

  ldc_decoder #(.BUSY_CYCLES_P(BUSY_P), .BLINK_CYCLES_P(BLINK_P)) ldc_decoder_i (
    .CLK(clk), .RESET_N(reset_n), .INSTR_VALID(instr_valid), .INSTR_DATA(instr_data),
    .EXTENSION_DRIVER_SELECT(xdrv_sel), .BUSY(busy), .PANEL_DRIVE(panel),
    .CURSOR_ENABLE(cur_en), .BLINK_ENABLE(blink_en), .CURSOR_SHOWN(cur_shown),
    .CURSOR_ALL_ON(all_on), .CURSOR_INVERT(cur_inv), .FONT_WIDTH_SELECT(font6),
    .GLYPH_ROW_MASK(row_mask), .FOUR_LINE_ENABLE(four), .LINE_MODE(line_mode),
    .LINE_SCROLL_ENABLE(scroll), .BUS_WIDTH_SELECT(bw), .PAGE_BIT(page),
    .GLYPH_BLINK_ENABLE(gblink), .LOW_POWER_ENABLE(lowpow), .CLOCK_DIVIDE(div),
    .FRAME_RATE_REDUCED(slow), .ADDRESS_POINTER(ptr), .RAM_TARGET(target),
    .DISPLAY_SHIFT_OFFSET(offset), .DISPLAY_SHIFT_PULSE(pulse));

  ldc_host_model ldc_host_model_i (
    .clk(clk), .busy(busy), .instr_valid(instr_valid), .instr_data(instr_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // sends one byte, then measures how long busy stands and counts shift pulses
  task automatic run(input logic [7:0] b);
    bit ok;
    int n;
    ldc_host_model_i.send(b, 1'b0, ok);
    #1;
    n = 0;
    pulses = 0;
    while (busy === 1'b1 && n < 1000) begin
      pulses += int'(pulse);
      @(posedge clk);
      #1;
      n++;
    end
    if (!ok || n >= 1000) begin
      err_count++;
      print_verdict();
    end
    chk(8'(n), 8'(lat));
  endtask

  task automatic blink_count(input bit inv, output int n);
    logic p, q;
    n = 0;
    p = inv ? cur_inv : all_on;
    repeat (40) begin
      @(posedge clk);
      #1;
      q = inv ? cur_inv : all_on;
      if (q !== p) n++;
      p = q;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_display();
    for (int i = 0; i < 8; i++) begin
      run(8'h08 | 8'(i));
      chk({5'h00, panel, cur_en, blink_en}, 8'(i));
      chk({7'h00, cur_shown}, {7'h00, i[2] & i[1]});
    end
  endtask

  task automatic t_blink();
    int n;
    blink_count(1'b0, n);
    chk(8'(n), 8'(40 / BLINK_P));
    run(8'h3C);
    run(8'h0A);
    chk({6'h00, cur_shown, all_on}, 8'h00);
    blink_count(1'b1, n);
    chk(8'(n), 8'(40 / BLINK_P));
    blink_count(1'b0, n);
    chk(8'(n), 8'h00);
  endtask

  task automatic t_ext();
    lat = BUSY_P * 6 / 5;
    run(8'h0C);
    chk({1'b0, font6, row_mask}, 8'h7F);
    lat = BUSY_P;
    run(8'h09);
    chk({font6, four, 4'h0, 2'(line_mode)}, 8'h42);
    run(8'h34);
    chk({6'h00, 2'(line_mode)}, 8'h02);
    run(8'h08);
    chk({6'h00, 2'(line_mode)}, 8'h00);
    run(8'h3C);
    chk({6'h00, 2'(line_mode)}, 8'h01);
  endtask

  task automatic t_scroll_addr();
    run(8'h13);
    chk({4'h0, scroll}, 8'h03);
    run(8'h1C);
    chk({4'h0, scroll}, 8'h0C);
    run(8'h7A);
    chk({target, ptr[5:0]}, {LDC_RAM_ICON, 6'h0A});
    run(8'hFF);
    chk({target, ptr[5:0]}, {LDC_RAM_ICON, 6'h0A});
    run(8'h38);
    chk({7'h00, page}, 8'h00);
    run(8'h10);
    chk({target, ptr[5:0]}, {LDC_RAM_ICON, 6'h09});
    run(8'h7F);
    chk({target, ptr[5:0]}, {LDC_RAM_GLYPH, 6'h3F});
    run(8'h14);
    chk({1'b0, ptr}, 8'h00);
  endtask

  task automatic t_cursor();
    run(8'hA7);
    run(8'h14);
    chk({1'b0, ptr}, 8'h40);
    run(8'h10);
    chk({1'b0, ptr}, 8'h27);
    run(8'h17);
    chk({target, ptr[5:0]}, {LDC_RAM_TEXT, 6'h00});
    run(8'h3C);
    run(8'h09);
    run(8'h38);
    run(8'h93);
    run(8'h14);
    chk({1'b0, ptr}, 8'h20);
    run(8'h3C);
    run(8'h08);
    run(8'h38);
  endtask

  task automatic t_dshift();
    logic [6:0] p0, o0;
    p0 = ptr;
    o0 = offset;
    run(8'h1C);
    chk(8'(pulses), 8'h01);
    chk({1'b0, offset}, 8'((int'(o0) + 1) % 40));
    run(8'h18);
    run(8'h18);
    chk({1'b0, offset}, 8'((int'(o0) + 39) % 40));
    chk({1'b0, ptr}, {1'b0, p0});
  endtask

  task automatic t_bus_refuse();
    bit ok;
    run(8'h28);
    chk({7'h00, bw}, 8'h00);
    run(8'h0B);
    chk({5'h00, panel, cur_en, blink_en}, 8'h03);
    run(8'h30);
    chk({bw, 5'h00, 2'(line_mode)}, 8'h80);
    ldc_host_model_i.send(8'h08, 1'b0, ok);
    if (!ok) begin
      err_count++;
      print_verdict();
    end
    ldc_host_model_i.send(8'h0C, 1'b1, ok);
    run(8'h00);
    chk({5'h00, panel, cur_en, blink_en}, 8'h00);
  endtask

  // no display shift is issued while low power is on
  task automatic t_low_power();
    run(8'h34);
    chk({7'h00, page}, 8'h01);
    lat = BUSY_P * 4;
    run(8'h37);
    chk({3'h0, lowpow, gblink, div}, 8'h1C);
    chk({7'h00, slow}, 8'h01);
    lat = BUSY_P * 2;
    run(8'h3F);
    chk({5'h00, div}, 8'h02);
    @(posedge clk);
    xdrv_sel <= 1'b1;
    lat = BUSY_P;
    run(8'h3D);
    chk({lowpow, slow, 3'h0, div}, 8'h81);
    run(8'h3C);
    chk({lowpow, gblink, 3'h0, div}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({busy, panel, cur_en, blink_en, font6, four, page, lowpow}, 8'h00);
    chk({bw, 1'b0, row_mask}, 8'h9F);
    chk({div, 1'b0, 2'(line_mode), 2'(target)}, 8'h20);
    chk({1'b0, ptr}, 8'h00);
    t_display();
    t_blink();
    t_ext();
    t_scroll_addr();
    t_cursor();
    t_dshift();
    t_bus_refuse();
    t_low_power();
    print_verdict();
  end
endmodule // lcd_display_control_decoder_tb
